// File: hw/fvmbc_pkg.sv
package fvmbc_pkg;

	// AXI4-Lite register map (byte addresses)
	localparam logic [7:0] FVMBC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] FVMBC_OFF_EXC    = 8'h04;
	localparam logic [7:0] FVMBC_OFF_EXINST = 8'h08;
	localparam logic [7:0] FVMBC_OFF_ID     = 8'h0C;
	localparam logic [7:0] FVMBC_OFF_STAT   = 8'h10;

	// Fields of the status/control register, and the flag bit of the exception register
	localparam int FVMBC_DNAN_BIT     = 25;
	localparam int FVMBC_FTZ_BIT      = 24;
	localparam int FVMBC_RMODE_LSB    = 22;
	localparam int FVMBC_STRIDE_LSB   = 20;
	localparam int FVMBC_VLEN_LSB     = 16;
	localparam int FVMBC_EN_LSB       = 8;
	localparam int FVMBC_EN_MSB       = 12;
	localparam int FVMBC_EXC_FLAG_BIT = 31;
	localparam logic [31:0] FVMBC_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FVMBC_CTRL_WMASK = 32'h03F7_1F00;

	// Instruction word layout used by the sequencer
	localparam int FVMBC_FD_LSB = 12;
	localparam int FVMBC_FN_LSB = 16;
	localparam int FVMBC_FM_LSB = 0;

	// Rounding modes
	typedef enum logic [1:0] {
		FVMBC_RNE = 2'h0,
		FVMBC_RPI = 2'h1,
		FVMBC_RMI = 2'h2,
		FVMBC_RTZ = 2'h3
	} fvmbc_rmode_e;

	// Issued instruction class
	typedef enum logic [2:0] {
		FVMBC_OP_ARITH = 3'h0,
		FVMBC_OP_MOVTO = 3'h1,
		FVMBC_OP_MOVFR = 3'h2,
		FVMBC_OP_LDST  = 3'h3,
		FVMBC_OP_ILL   = 3'h4
	} fvmbc_op_e;

	// System register selectors for moves
	localparam logic [3:0] FVMBC_SR_ID  = 4'h0;
	localparam logic [3:0] FVMBC_SR_CTL = 4'h1;
	localparam logic [3:0] FVMBC_SR_EXC = 4'h8;
	localparam logic [3:0] FVMBC_SR_INS = 4'h9;

	typedef struct packed {
		logic        valid;
		fvmbc_op_e   op;
		logic [3:0]  sreg;
		logic        pot_exc;
		logic        unsup;
		logic        exc_cond;
		logic [4:0]  exc_kind;
		logic [31:0] word;
	} fvmbc_issue_s;

	typedef struct packed {
		logic        bounce;
		logic        accept;
	} fvmbc_resp_s;

	typedef enum logic [2:0] {
		FVMBC_ST_IDLE = 3'b001,
		FVMBC_ST_VEC  = 3'b010,
		FVMBC_ST_EXC  = 3'b100
	} fvmbc_state_e;

endpackage : fvmbc_pkg

// File: hw/fvmbc_round.sv
`timescale 1ns/10ps
// Rounds a double-width significand product to W bits
module fvmbc_round
	import fvmbc_pkg::*;
#(
	parameter int W = 24
) (
	input  wire logic [2*W-1:0] prod,
	input  wire logic           sign,
	input  wire fvmbc_rmode_e   mode,
	output logic      [W:0]     sig_out,
	output logic                inexact
);
	if (W < 2) begin : g_bad_w
		$error("fvmbc_round: W too small");
	end

	wire logic [W-1:0] keep   = prod[2*W-1:W];
	wire logic         guard  = prod[W-1];
	wire logic         sticky = |prod[W-2:0];
	wire logic         rne_up = guard & (sticky | keep[0]);
	wire logic         up_inc;

	// Product kept at full width so rounding sees every bit
	assign inexact = guard | sticky;
	assign up_inc  = (mode == FVMBC_RNE) ? rne_up :
			(mode == FVMBC_RPI) ? (inexact & ~sign) :
			(mode == FVMBC_RMI) ? (inexact & sign) :
			1'b0;
	assign sig_out = {1'b0, keep} + {{W{1'b0}}, up_inc};
endmodule : fvmbc_round

// File: hw/fvmbc_vstep.sv
`timescale 1ns/10ps
// Register address of one operand for a given vector iteration
module fvmbc_vstep #(
	parameter int AW = 5
) (
	input  wire logic [AW-1:0] base,
	input  wire logic [2:0]    iter,
	input  wire logic [1:0]    stride,
	output logic      [AW-1:0] addr
);
	if (AW < 3) begin : g_bad_aw
		$error("fvmbc_vstep: AW too small");
	end
	wire logic [AW-1:0] step;
	wire logic [AW-1:0] off;

	// 00 steps by one, 11 by two; others treated as one
	assign step = (stride == 2'h3) ? AW'(2) : AW'(1);
	assign off  = AW'(step * AW'(iter));
	// Wrap inside the 8-register bank
	assign addr = {base[AW-1:3], 3'(base[2:0] + off[2:0])};
endmodule : fvmbc_vstep

// File: hw/fvmbc_top.sv
`timescale 1ns/10ps
// Behaviour
// - fast mode needs default NaN, flush, no enables
// - fast mode never bounces legal operations; here they still bounce while the exceptional flag is set
// - fast mode returns standard results
// - default NaN replaces every NaN result
// - stride 00 steps registers by one
// - stride 11 steps registers by two
// - nearest mode ties go to even
// - toward-zero mode truncates without increment
// - four rounding modes are supported
// - products keep double-width significand before rounding
// - outside fast mode, potentially exceptional issue enters exceptional state
// - next instruction bounces except system moves of the ID, EXC and INS registers
// - bounced trigger not executed, stays retryable
// - outside fast mode, unsupported operands bounce to support code
// - enabled exceptional condition traps to user
// - odd field values never hang the device
// - bounce asserted one cycle after the trigger is in decode
// - entry sets flag, saves iteration's word
// - flush-to-zero replaces subnormals with plus zero
module fvmbc_top
	import fvmbc_pkg::*;
#(
	parameter int          SIG_W   = 24,
	parameter logic [31:0] ID_CODE = 32'h0000_5A01 // Arbitrary value
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_awaddr,
	input  wire logic                 s_awvalid,
	output logic                      s_awready,
	input  wire logic [31:0]          s_wdata,
	input  wire logic [3:0]           s_wstrb,
	input  wire logic                 s_wvalid,
	output logic                      s_wready,
	output logic [1:0]                s_bresp,
	output logic                      s_bvalid,
	input  wire logic                 s_bready,
	input  wire logic [7:0]           s_araddr,
	input  wire logic                 s_arvalid,
	output logic                      s_arready,
	output logic [31:0]               s_rdata,
	output logic [1:0]                s_rresp,
	output logic                      s_rvalid,
	input  wire logic                 s_rready,
	// Host instruction interface, decode stage
	input  wire fvmbc_issue_s         issue,
	output fvmbc_resp_s               resp,
	// Iteration operand addresses
	output logic [4:0]                vec_fd,
	output logic [4:0]                vec_fn,
	output logic [4:0]                vec_fm,
	output logic                      vec_active,
	// Result control to the datapath
	output logic                      fast_no_bounce_mode,
	output logic                      default_nan_enable,
	output logic                      flush_to_zero_enable,
	output logic                      user_trap,
	// Rounding of a product, and the NaN/flush result override
	input  wire logic [2*SIG_W-1:0]   mul_prod,
	input  wire logic                 mul_sign,
	input  wire logic                 res_is_nan,
	input  wire logic                 res_subnormal,
	input  wire logic [31:0]          res_raw,
	output logic [31:0]               res_out,
	output logic [SIG_W:0]            mul_sig_q
);
	if (SIG_W < 2 || SIG_W > 53) begin : g_bad_sig
		$error("fvmbc_top: bad SIG_W");
	end

	localparam logic [31:0] DEF_NAN = 32'h7FC0_0000;
	localparam logic [31:0] POS_ZERO = 32'h0000_0000;

	logic [31:0]  fp_status_control_reg_q;
	logic [31:0]  fp_exception_instr_reg_q;
	logic         exceptional_state_flag_q;
	fvmbc_state_e state_q, state_d;
	logic [2:0]   iter_q, iter_d;

	// Control decode
	wire logic [2:0] vector_length_field =
		fp_status_control_reg_q[FVMBC_VLEN_LSB +: 3];
	wire logic [1:0] stride = fp_status_control_reg_q[FVMBC_STRIDE_LSB +: 2];
	wire logic [4:0] exc_en =
		fp_status_control_reg_q[FVMBC_EN_MSB:FVMBC_EN_LSB];
	wire fvmbc_rmode_e rmode =
		fvmbc_rmode_e'(fp_status_control_reg_q[FVMBC_RMODE_LSB +: 2]);
	wire logic dnan_w = fp_status_control_reg_q[FVMBC_DNAN_BIT];
	wire logic ftz_w  = fp_status_control_reg_q[FVMBC_FTZ_BIT];
	wire logic fast_w = dnan_w & ftz_w & (exc_en == 5'h00);

	// Issue decode
	wire logic is_sysmove = (issue.op == FVMBC_OP_MOVTO) |
		(issue.op == FVMBC_OP_MOVFR);
	wire logic sysmove_exempt = is_sysmove &
		((issue.sreg == FVMBC_SR_EXC) | (issue.sreg == FVMBC_SR_INS) |
		 (issue.sreg == FVMBC_SR_ID));
	wire logic trig_bounce = exceptional_state_flag_q & issue.valid &
		~sysmove_exempt;
	wire logic legal_arith = issue.valid & (issue.op == FVMBC_OP_ARITH) &
		~exceptional_state_flag_q;
	// Fast mode forbids every operand bounce
	wire logic unsup_bounce = legal_arith & issue.unsup & ~fast_w;
	wire logic ill_bounce = issue.valid & (issue.op == FVMBC_OP_ILL);
	wire logic bounce_w = trig_bounce | unsup_bounce | ill_bounce;
	// Potentially exceptional only when not in fast mode
	wire logic enter_exc = legal_arith & issue.pot_exc & ~fast_w &
		~issue.unsup;
	wire logic accept_w = issue.valid & ~bounce_w;
	wire logic busy_vec = (state_q == FVMBC_ST_VEC);

	// Vector sequencer
	wire logic [2:0] last_iter = vector_length_field;
	wire logic start_vec = accept_w & (issue.op == FVMBC_OP_ARITH) &
		~busy_vec & (last_iter != 3'h0);
	logic [31:0] word_q;
	wire logic [4:0] base_fd = {word_q[FVMBC_FD_LSB +: 4], 1'b0};
	wire logic [4:0] base_fn = {word_q[FVMBC_FN_LSB +: 4], 1'b0};
	wire logic [4:0] base_fm = {word_q[FVMBC_FM_LSB +: 4], 1'b0};
	wire logic [4:0] a_fd, a_fn, a_fm;

	fvmbc_vstep #(.AW(5)) u_step_fd (
		.base   (base_fd),
		.iter   (iter_q),
		.stride (stride),
		.addr   (a_fd)
	);
	fvmbc_vstep #(.AW(5)) u_step_fn (
		.base   (base_fn),
		.iter   (iter_q),
		.stride (stride),
		.addr   (a_fn)
	);
	fvmbc_vstep #(.AW(5)) u_step_fm (
		.base   (base_fm),
		.iter   (iter_q),
		.stride (stride),
		.addr   (a_fm)
	);

	// IDLE waits for an issue; every other state leaves by itself or on a register write that clears the flag, never stalls
	always_comb begin
		state_d = state_q;
		iter_d  = iter_q;
		unique case (state_q)
			FVMBC_ST_IDLE: begin
				iter_d = 3'h0;
				if (enter_exc)
					state_d = FVMBC_ST_EXC;
				else if (start_vec)
					state_d = FVMBC_ST_VEC;
			end
			FVMBC_ST_VEC: begin
				if (iter_q == last_iter) begin
					state_d = FVMBC_ST_IDLE;
					iter_d  = 3'h0;
				end else begin
					iter_d = 3'(iter_q + 3'h1);
				end
			end
			FVMBC_ST_EXC: begin
				if (!exceptional_state_flag_q)
					state_d = FVMBC_ST_IDLE;
			end
			default: begin
				state_d = FVMBC_ST_IDLE;
				iter_d  = 3'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= FVMBC_ST_IDLE;
			iter_q  <= 3'h0;
			word_q  <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			iter_q  <= iter_d;
			if (accept_w && !busy_vec)
				word_q <= issue.word;
		end
	end

	// Saved word carries this iteration's register fields
	wire logic [31:0] saved_word = busy_vec ?
		{word_q[31:20], a_fn[4:1], a_fd[4:1], word_q[11:4], a_fm[4:1]} :
		issue.word;

	// AXI4-Lite slave
	logic        aw_hold_q, w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	wire logic   aw_take = s_awvalid & s_awready;
	wire logic   w_take  = s_wvalid & s_wready;
	wire logic   have_aw = aw_hold_q | aw_take;
	wire logic   have_w  = w_hold_q | w_take;
	wire logic   do_wr   = have_aw & have_w & ~s_bvalid;
	wire logic [7:0]  wa = aw_hold_q ? awaddr_q : s_awaddr;
	wire logic [31:0] wd = w_hold_q ? wdata_q : s_wdata;
	wire logic [3:0]  ws = w_hold_q ? wstrb_q : s_wstrb;
	wire logic [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}},
		{8{ws[1]}}, {8{ws[0]}}};
	wire logic wr_ctrl = do_wr & (wa == FVMBC_OFF_CTRL);
	wire logic wr_exc  = do_wr & (wa == FVMBC_OFF_EXC);
	wire logic wr_ok   = (wa == FVMBC_OFF_CTRL) | (wa == FVMBC_OFF_EXC) |
		(wa == FVMBC_OFF_EXINST) | (wa == FVMBC_OFF_ID) |
		(wa == FVMBC_OFF_STAT);
	wire logic [31:0] ctrl_new = (fp_status_control_reg_q & ~bmask) |
		(wd & bmask & FVMBC_CTRL_WMASK);
	// Software clears the flag by writing zero to bit 31; entry wins
	wire logic flag_clr = wr_exc & ws[3] & ~wd[FVMBC_EXC_FLAG_BIT];
	wire logic [31:0] stat_word = {27'h0, iter_q, fast_w, busy_vec};
	wire logic [31:0] rd_mux =
		(s_araddr == FVMBC_OFF_CTRL)   ? fp_status_control_reg_q :
		(s_araddr == FVMBC_OFF_EXC)    ? {exceptional_state_flag_q, 31'h0} :
		(s_araddr == FVMBC_OFF_EXINST) ? fp_exception_instr_reg_q :
		(s_araddr == FVMBC_OFF_ID)     ? ID_CODE :
		(s_araddr == FVMBC_OFF_STAT)   ? stat_word : 32'h0000_0000;
	wire logic rd_ok = (s_araddr == FVMBC_OFF_CTRL) |
		(s_araddr == FVMBC_OFF_EXC) | (s_araddr == FVMBC_OFF_EXINST) |
		(s_araddr == FVMBC_OFF_ID) | (s_araddr == FVMBC_OFF_STAT);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= 2'h0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			s_awready <= ~have_aw & ~s_bvalid & ~s_awready;
			s_wready  <= ~have_w & ~s_bvalid & ~s_wready;
			if (aw_take) begin
				awaddr_q <= s_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			aw_hold_q <= have_aw & ~do_wr;
			w_hold_q  <= have_w & ~do_wr;
			if (do_wr) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= 2'h0;
		end else begin
			s_arready <= ~s_rvalid & ~s_arready & s_arvalid;
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rdata  <= rd_mux;
				s_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// Control and exception registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fp_status_control_reg_q  <= FVMBC_CTRL_RST;
			fp_exception_instr_reg_q <= 32'h0000_0000;
			exceptional_state_flag_q <= 1'b0;
		end else begin
			if (wr_ctrl)
				fp_status_control_reg_q <= ctrl_new;
			if (enter_exc) begin
				exceptional_state_flag_q <= 1'b1;
				fp_exception_instr_reg_q <= saved_word;
			end else if (flag_clr) begin
				exceptional_state_flag_q <= 1'b0;
			end
		end
	end

	// Host response and result path
	wire logic [SIG_W:0] sig_w;
	wire logic           inexact_w;

	fvmbc_round #(.W(SIG_W)) u_round (
		.prod    (mul_prod),
		.sign    (mul_sign),
		.mode    (rmode),
		.sig_out (sig_w),
		.inexact (inexact_w)
	);

	// Flush beats NaN: a subnormal can never be a NaN pattern anyway
	wire logic [31:0] res_w = (ftz_w & res_subnormal) ? POS_ZERO :
		(dnan_w & res_is_nan) ? DEF_NAN : res_raw;
	wire logic trap_w = legal_arith & issue.exc_cond & ~issue.unsup &
		|(issue.exc_kind & exc_en);

	// One driver for the whole answer word
	wire fvmbc_resp_s resp_d =
		'{bounce: bounce_w, accept: accept_w};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resp                 <= '0;
			vec_fd               <= 5'h00;
			vec_fn               <= 5'h00;
			vec_fm               <= 5'h00;
			vec_active           <= 1'b0;
			fast_no_bounce_mode  <= 1'b0;
			default_nan_enable   <= 1'b0;
			flush_to_zero_enable <= 1'b0;
			user_trap            <= 1'b0;
			res_out              <= 32'h0000_0000;
			mul_sig_q            <= '0;
		end else begin
			resp                 <= resp_d;
			vec_fd               <= a_fd;
			vec_fn               <= a_fn;
			vec_fm               <= a_fm;
			vec_active           <= busy_vec;
			fast_no_bounce_mode  <= fast_w;
			default_nan_enable   <= dnan_w;
			flush_to_zero_enable <= ftz_w;
			user_trap            <= trap_w;
			res_out              <= res_w;
			mul_sig_q            <= sig_w;
		end
	end

	// Assertions
	// Checked against the raw control bits, not the shared decode wire
	property p_fast_mode;
		@(posedge clk) disable iff (!rst_b)
		##1 fast_no_bounce_mode ==
		($past(fp_status_control_reg_q[FVMBC_DNAN_BIT]) &
		 $past(fp_status_control_reg_q[FVMBC_FTZ_BIT]) &
		 ~|$past(exc_en));
	endproperty
	a_fast_mode: assert property (p_fast_mode)
		else $error("fast mode flag wrong");

	property p_fast_no_bounce;
		@(posedge clk) disable iff (!rst_b)
		(fast_w && issue.valid && issue.op == FVMBC_OP_ARITH &&
		 !exceptional_state_flag_q) |=> !resp.bounce;
	endproperty
	a_fast_no_bounce: assert property (p_fast_no_bounce)
		else $error("bounce in fast mode");

	property p_dnan;
		@(posedge clk) disable iff (!rst_b)
		(dnan_w && res_is_nan && !(ftz_w && res_subnormal)) |=>
		res_out == DEF_NAN;
	endproperty
	a_dnan: assert property (p_dnan)
		else $error("default NaN not returned");

	property p_ftz;
		@(posedge clk) disable iff (!rst_b)
		(ftz_w && res_subnormal) |=> res_out == POS_ZERO;
	endproperty
	a_ftz: assert property (p_ftz)
		else $error("subnormal not flushed");

	property p_trigger;
		@(posedge clk) disable iff (!rst_b)
		(exceptional_state_flag_q && issue.valid && !sysmove_exempt) |=>
		(resp.bounce && !resp.accept);
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("trigger not bounced");

	property p_exempt;
		@(posedge clk) disable iff (!rst_b)
		(exceptional_state_flag_q && issue.valid && sysmove_exempt) |=>
		!resp.bounce;
	endproperty
	a_exempt: assert property (p_exempt)
		else $error("exempt move bounced");

	property p_enter;
		@(posedge clk) disable iff (!rst_b)
		enter_exc |=> exceptional_state_flag_q &&
		fp_exception_instr_reg_q == $past(saved_word);
	endproperty
	a_enter: assert property (p_enter)
		else $error("exceptional entry not recorded");

	property p_vec_len;
		@(posedge clk) disable iff (!rst_b)
		($rose(busy_vec) && vector_length_field == 3'h3 && !wr_ctrl) |->
		busy_vec [*4] ##1 !busy_vec;
	endproperty
	a_vec_len: assert property (p_vec_len)
		else $error("vector length wrong");

	property p_stride2;
		@(posedge clk) disable iff (!rst_b)
		(busy_vec && stride == 2'h3 && iter_q == 3'h1) |->
		a_fd[2:0] == 3'(base_fd[2:0] + 3'h2);
	endproperty
	a_stride2: assert property (p_stride2)
		else $error("stride two step wrong");

	property p_rtz;
		@(posedge clk) disable iff (!rst_b)
		(rmode == FVMBC_RTZ) |=>
		mul_sig_q == {1'b0, $past(mul_prod[2*SIG_W-1:SIG_W])};
	endproperty
	a_rtz: assert property (p_rtz)
		else $error("truncation incremented");

	c_bounce: cover property (@(posedge clk) disable iff (!rst_b)
		enter_exc ##[1:20] resp.bounce);
	c_vector: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(busy_vec) ##3 busy_vec);
	c_fast: cover property (@(posedge clk) disable iff (!rst_b)
		fast_w && legal_arith && issue.unsup);
endmodule : fvmbc_top

// File: sim/fvmbc_host_model.sv
`timescale 1ns/10ps
// Host core in decode stage: one instruction slot per call
module fvmbc_host_model
	import fvmbc_pkg::*;
(
	input  wire logic        clk,
	input  wire fvmbc_resp_s resp,
	output fvmbc_issue_s     issue
);
	initial issue = '0;

	// The slot is held for one edge only; a retry is a fresh call
	task automatic send(input fvmbc_op_e o, input logic [3:0] sr,
		input logic pe, us, ec, input logic [4:0] k,
		input logic [31:0] wd);
		issue <= '{1'b1, o, sr, pe, us, ec, k, wd};
		@(posedge clk);
		issue.valid <= 1'b0;
		@(posedge clk);
	endtask : send
endmodule : fvmbc_host_model

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
	import fvmbc_pkg::*;
	localparam int          W  = 8;
	localparam logic [31:0] ID = 32'h0000_3C5A; // Arbitrary value
	logic           clk = 1'b0;
	logic           rst_b = 1'b0;
	logic [7:0]     s_awaddr = '0, s_araddr = '0;
	logic [31:0]    s_wdata = '0, res_raw = '0, s_rdata, res_out;
	logic           s_awvalid = 0, s_wvalid = 0, s_bready = 0;
	logic           s_arvalid = 0, s_rready = 0, mul_sign = 0;
	logic           res_is_nan = 0, res_subnormal = 0;
	logic [2*W-1:0] mul_prod = '0;
	logic [3:0]     s_wstrb = 4'hF;
	logic           s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]     s_bresp, s_rresp;
	fvmbc_issue_s   issue;
	fvmbc_resp_s    resp;
	logic [4:0]     vec_fd, vec_fn, vec_fm;
	logic           vec_active, fast_no_bounce_mode, user_trap;
	logic           default_nan_enable, flush_to_zero_enable;
	logic [W:0]     mul_sig_q;
	logic [65:0]    exp_rd[$];
	logic [2:0]     exp_rs[$];
	logic [14:0]    exp_vec[$];
	logic [65:0]    rt;
	int             bad_count = 0;
	int             num_checks = 0;
	integer         seed = 32'h1ecb;

	fvmbc_top #(.SIG_W(W), .ID_CODE(ID)) dut_u (.clk, .rst_b, .s_awaddr,
		.s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
		.s_rdata, .s_rresp, .s_rvalid, .s_rready, .issue, .resp, .vec_fd,
		.vec_fn, .vec_fm, .vec_active, .fast_no_bounce_mode,
		.default_nan_enable, .flush_to_zero_enable, .user_trap, .mul_prod,
		.mul_sign, .res_is_nan, .res_subnormal, .res_raw, .res_out,
		.mul_sig_q);
	fvmbc_host_model host_u (.clk, .resp, .issue);

	always #5 clk = ~clk;

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		// bready stays up, so back-to-back writes never re-raise it
		chk("bresp", s_bresp, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		exp_rd.push_back({m, e});
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
	endtask : rd

	// Expected answer is {user_trap, bounce, accept}
	task automatic op(input fvmbc_op_e o, input logic [3:0] sr,
		input logic pe, us, ec, input logic [4:0] k,
		input logic [31:0] wd, input logic [2:0] e);
		exp_rs.push_back(e);
		host_u.send(o, sr, pe, us, ec, k, wd);
	endtask : op

	function automatic logic [4:0] va(input logic [3:0] b, input int k, st);
		logic [2:0] lo;
		lo = {b[1:0], 1'b0} + 3'(k * st);
		return {b[3:2], lo};
	endfunction : va

	always @(posedge clk) begin
		if (s_rvalid && s_rready) begin
			rt = exp_rd.pop_front();
			chk("rdata", {s_rresp, s_rdata} & {2'h3, rt[65:34]}, rt[33:0]);
		end
		if (resp.bounce || resp.accept) begin
			chk("resp", {user_trap, resp.bounce, resp.accept}, exp_rs.pop_front());
		end
		if (vec_active) begin
			chk("vec", {vec_fd, vec_fn, vec_fm}, exp_vec.pop_front());
		end
	end

	initial begin
		#100us;
		bad_count++;
		$display("watchdog expired");
		end_of_test();
	end

	initial begin
		logic [31:0] wd, cv;
		logic [3:0]  fd, fn, fm;
		logic [35:0] rtab [9];
		rtab = '{36'h0_0_8580_086, 36'h0_0_8480_084, 36'h0_0_8481_085,
			36'h3_0_84FF_084, 36'h1_0_8401_085, 36'h1_1_8401_084,
			36'h2_1_8401_085, 36'h2_0_8401_084, 36'h0_0_FF80_100};
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(FVMBC_OFF_CTRL, {2'h0, FVMBC_CTRL_RST});
		rd(FVMBC_OFF_ID, {2'h0, ID});
		rd(8'h14, {2'h2, 32'h0});
		wr(8'h14, 32'hFFFF_FFFF, 2'h2);
		rd(FVMBC_OFF_CTRL, 34'h0);
		// Only byte lane 2 lands, and only its writable bits
		s_wstrb <= 4'h4;
		wr(FVMBC_OFF_CTRL, 32'hFFFF_FFFF, 2'h0);
		s_wstrb <= 4'hF;
		rd(FVMBC_OFF_CTRL, {2'h0, FVMBC_CTRL_WMASK & 32'h00FF_0000});
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			cv = (i < 6) ? (32'h0300_0000 | ((i == 0) ? 32'h0 : 32'h80 << i))
				: (32'h0400_0000 >> (i - 5));
			wr(FVMBC_OFF_CTRL, cv, 2'h0);
			repeat (2) @(posedge clk);
			chk("fast", fast_no_bounce_mode, i == 0);
			chk("dnfz", {default_nan_enable, flush_to_zero_enable}, cv[25:24]);
		end
		wr(FVMBC_OFF_CTRL, 32'h0300_0000, 2'h0);
		op(FVMBC_OP_ARITH, 4'h0, 0, 1, 0, 5'h0, 32'h0, 3'b001);
		op(FVMBC_OP_ARITH, 4'h0, 1, 0, 0, 5'h0, 32'h0, 3'b001);
		op(FVMBC_OP_ARITH, 4'h0, 0, 0, 0, 5'h0, 32'h0, 3'b001);
		res_is_nan <= 1'b1;
		res_raw <= $random(seed);
		repeat (2) @(posedge clk);
		chk("dnan", res_out[30:0], 31'h7FC0_0000);
		res_is_nan <= 1'b0;
		res_subnormal <= 1'b1;
		repeat (2) @(posedge clk);
		chk("flush", res_out, 32'h0);
		$display("test fast mode done");
		wr(FVMBC_OFF_CTRL, 32'h0000_0100, 2'h0);
		res_is_nan <= 1'b1;
		repeat (2) @(posedge clk);
		chk("raw", res_out, res_raw);
		res_is_nan <= 1'b0;
		res_subnormal <= 1'b0;
		op(FVMBC_OP_ARITH, 4'h0, 0, 0, 1, 5'h01, 32'h0, 3'b101);
		op(FVMBC_OP_ARITH, 4'h0, 0, 0, 1, 5'h02, 32'h0, 3'b001);
		op(FVMBC_OP_ARITH, 4'h0, 0, 1, 0, 5'h0, 32'h0, 3'b010);
		op(FVMBC_OP_ILL, 4'h0, 0, 0, 0, 5'h0, 32'h0, 3'b010);
		wd = $random(seed);
		op(FVMBC_OP_ARITH, 4'h0, 1, 0, 0, 5'h0, wd, 3'b001);
		op(FVMBC_OP_ARITH, 4'h0, 0, 0, 0, 5'h0, wd, 3'b010);
		op(FVMBC_OP_MOVFR, FVMBC_SR_EXC, 0, 0, 0, 5'h0, 0, 3'b001);
		op(FVMBC_OP_MOVFR, FVMBC_SR_INS, 0, 0, 0, 5'h0, 0, 3'b001);
		op(FVMBC_OP_MOVFR, FVMBC_SR_ID, 0, 0, 0, 5'h0, 0, 3'b001);
		op(FVMBC_OP_MOVTO, FVMBC_SR_ID, 0, 0, 0, 5'h0, 0, 3'b001);
		op(FVMBC_OP_MOVFR, FVMBC_SR_CTL, 0, 0, 0, 5'h0, 0, 3'b010);
		op(FVMBC_OP_LDST, 4'h0, 0, 0, 0, 5'h0, 32'h0, 3'b010);
		rd(FVMBC_OFF_EXC, {2'h0, 32'h8000_0000}, 32'h8000_0000);
		rd(FVMBC_OFF_EXINST, {2'h0, wd});
		wr(FVMBC_OFF_EXC, 32'h0, 2'h0);
		rd(FVMBC_OFF_EXC, 34'h0, 32'h8000_0000);
		op(FVMBC_OP_ARITH, 4'h0, 0, 0, 0, 5'h0, wd, 3'b001);
		$display("test exceptional state done");
		for (int s = 0; s < 4; s++) begin
			wr(FVMBC_OFF_CTRL, (s << FVMBC_STRIDE_LSB) | 32'h0003_0000, 2'h0);
			{fd, fn, fm} = 12'($random(seed));
			for (int k = 0; k < 4; k++) begin
				exp_vec.push_back({va(fd, k, (s == 3) ? 2 : 1),
					va(fn, k, (s == 3) ? 2 : 1), va(fm, k, (s == 3) ? 2 : 1)});
			end
			op(FVMBC_OP_ARITH, 4'h0, 0, 0, 0, 5'h0,
				{12'h0, fn, fd, 8'h0, fm}, 3'b001);
			repeat (8) @(posedge clk);
			chk("vec_count", exp_vec.size(), 0);
		end
		$display("test vector done");
		for (int i = 0; i < 9; i++) begin
			wr(FVMBC_OFF_CTRL, 32'(rtab[i][33:32]) << FVMBC_RMODE_LSB, 2'h0);
			mul_sign <= rtab[i][28];
			mul_prod <= rtab[i][27:12];
			repeat (2) @(posedge clk);
			chk("round", mul_sig_q, rtab[i][8:0]);
		end
		$display("test rounding done");
		chk("pending", exp_rs.size() + exp_rd.size(), 0);
		end_of_test();
	end
endmodule : tb
